// File: rtl/tweb_pkg.sv
// Purpose: Shared constants and types for the two-wire target bus-condition block.
// Assumes: One 100 MHz system clock; the serial clock is sampled as a plain input.
// Notes:   Device address layout is a fixed 4-bit type code plus a 3-bit select field.
package tweb_pkg;
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          WORD_BITS     = 8;
    localparam int          ACK_SLOT      = 8;
    localparam logic [3:0]  TYPE_CODE     = 4'h_A;
    localparam int          RW_BIT        = 0;
    localparam int          SEL_LSB       = 1;
    localparam int          SEL_W         = 3;
    localparam int          TYPE_LSB      = 4;
    localparam logic [3:0]  BIT_CNT_RST   = 4'h_0;
    localparam logic [7:0]  SHIFT_RST     = 8'h_00;
    localparam logic [1:0]  SYNC_RST      = 2'h_3;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_ADDR    = 3'b001,
        ST_RX      = 3'b010,
        ST_TX      = 3'b011,
        ST_ACK     = 3'b100,
        ST_MACK    = 3'b101
    } tweb_state_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } tweb_edge_t;

    typedef struct packed {
        logic start;
        logic stop;
    } tweb_cond_t;
endpackage

// File: rtl/tweb_sync.sv
// Purpose: Two-flop synchroniser with edge detection on the second stage.
// Assumes: Input is asynchronous to the clock.
// Notes:   The first stage feeds only the second stage, so no logic sees a metastable value.
module tweb_sync
    import tweb_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             pin_i,
    output tweb_pkg::tweb_edge_t  edge_o
);
    logic [1:0] stage;
    logic       last;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage <= SYNC_RST;
            last  <= 1'b1;
        end else begin
            stage <= {stage[0], pin_i};
            last  <= stage[1];
        end
    end

    assign edge_o.level = stage[1];
    assign edge_o.rise  = stage[1] & ~last;
    assign edge_o.fall  = ~stage[1] & last;
endmodule

// File: rtl/tweb_target.sv
// Purpose: Target-side start/stop detection, word framing and acknowledge for a two-wire EEPROM.
// Assumes: SCL and SDA arrive from the bus master asynchronously; memory core sits outside.
// Notes:   Data path to the array is a byte strobe out and a byte in; no buffering.
module tweb_target
    import tweb_pkg::*;
(
    input  wire logic                          MCLK_I,
    input  wire logic                          RST_N_I,
    input  wire logic                          SCL_I,
    input  wire logic                          SDA_I,
    output logic                               SDA_O,
    output logic                               SDA_OE_O,
    input  wire logic [tweb_pkg::SEL_W-1:0]    DEV_SEL_I,
    input  wire logic                          WRITE_BUSY_I,
    input  wire logic [tweb_pkg::WORD_BITS-1:0] RD_DATA_I,
    output logic                               RD_NEXT_O,
    output logic [tweb_pkg::WORD_BITS-1:0]     WR_DATA_O,
    output logic                               WR_VALID_O,
    output logic                               STOP_O,
    output logic                               STANDBY_O,
    output logic                               READ_MODE_O
);
    import tweb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    tweb_edge_t scl;
    tweb_edge_t sda;
    tweb_cond_t cond;
    tweb_state_t state;
    logic [WORD_BITS-1:0] shift;
    logic [3:0]           bit_cnt;
    logic                 read_mode;
    logic                 word_done;
    logic                 addr_ok;
    logic                 mack_ok;
    logic                 pend_stop;
    logic                 slot_done;

    tweb_sync u_scl_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .pin_i   (SCL_I),
        .edge_o  (scl)
    );

    tweb_sync u_sda_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .pin_i   (SDA_I),
        .edge_o  (sda)
    );

    // SDA edges with SCL high are conditions, and are never shifted as data.
    assign cond.start = sda.fall & scl.level;
    assign cond.stop  = sda.rise & scl.level;

    assign word_done = scl.rise & (bit_cnt == 4'(WORD_BITS - 1));
    // The address must match and the array must be idle before we claim the bus.
    assign addr_ok = ({shift[WORD_BITS-2:0], sda.level} >> TYPE_LSB) == 8'(TYPE_CODE)
                   && shift[SEL_LSB+SEL_W-2:SEL_LSB-1] == DEV_SEL_I
                   && !WRITE_BUSY_I;
    // The master acknowledges a sent word by holding the line low in the ninth clock.
    assign mack_ok = ~sda.level;
    // Closing edge of the ninth clock: the count has passed the eight bits and the slot's own rise.
    // Both the device's slot and the master's slot end here.
    assign slot_done = scl.fall && (state == ST_ACK || state == ST_MACK)
                     && (bit_cnt == 4'(ACK_SLOT + 1));

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter and MSB-first shifter, sampled on SCL rising edges only.
    // Across a slot the count runs on to nine without shifting, so the falling edge that
    // closes the ninth clock is told apart from the one that opens the slot.
    // The shifter loads the array byte on that closing edge whenever a sent word follows.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            bit_cnt <= BIT_CNT_RST;
            shift   <= SHIFT_RST;
        end else if (cond.start || state == ST_STANDBY) begin
            bit_cnt <= BIT_CNT_RST;
        end else if (slot_done) begin
            bit_cnt <= BIT_CNT_RST;
            if (state == ST_MACK || read_mode) begin
                shift <= RD_DATA_I;
            end
        end else if (scl.rise) begin
            if (state != ST_ACK && state != ST_MACK) begin
                shift <= {shift[WORD_BITS-2:0], sda.level};
            end
            bit_cnt <= bit_cnt + 4'h_1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protocol state machine.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state     <= ST_STANDBY;
            read_mode <= 1'b0;
        end else if (cond.start) begin
            state     <= ST_ADDR;
            read_mode <= 1'b0;
        end else if (cond.stop) begin
            state <= ST_STANDBY;
        end else begin
            case (state)
                ST_STANDBY: state <= ST_STANDBY;
                ST_ADDR: begin
                    if (word_done) begin
                        if (addr_ok) begin
                            state     <= ST_ACK;
                            read_mode <= sda.level;
                        end else begin
                            state <= ST_STANDBY;
                        end
                    end
                end
                ST_RX: if (word_done) state <= ST_ACK;
                ST_TX: if (word_done) state <= ST_MACK;
                ST_ACK: begin
                    // Leave the slot on the falling edge that closes the ninth clock.
                    // The edge that opens it finds a count of eight and is passed over.
                    if (slot_done) begin
                        state <= read_mode ? ST_TX : ST_RX;
                    end
                end
                ST_MACK: begin
                    // A high slot means the master wants no more; wait in standby for its stop.
                    if (scl.rise && !mack_ok) begin
                        state <= ST_STANDBY;
                    end else if (slot_done) begin
                        state <= ST_TX;
                    end
                end
                default: state <= ST_STANDBY;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain drive: updated after SCL falling edges, and released at once on a start, a stop or in standby.
    // Only a release skips the wait; every pull-down waits for a falling edge, so the line is never pulled low while the clock is high.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            SDA_OE_O <= 1'b0;
        end else if (cond.start || cond.stop || state == ST_STANDBY) begin
            SDA_OE_O <= 1'b0;
        end else if (scl.fall) begin
            if (word_done_fall(state, bit_cnt)) begin
                SDA_OE_O <= 1'b1;
            end else if (state == ST_TX || (slot_done && (state == ST_MACK || read_mode))) begin
                SDA_OE_O <= ~next_tx_bit(state, shift, RD_DATA_I);
            end else begin
                // The master owns the line in its own acknowledge slot and in the next write word.
                SDA_OE_O <= 1'b0;
            end
        end
    end

    // Falling edge that opens the slot after the eighth bit of a received word.
    function automatic logic word_done_fall(input tweb_state_t s, input logic [3:0] n);
        word_done_fall = (s == ST_ACK) && (n == 4'(WORD_BITS));
    endfunction

    // Inside a word the next bit waits at the top of the shifter; at a slot's end it comes
    // straight from the array, because the shifter loads on that same edge.
    function automatic logic next_tx_bit(input tweb_state_t s, input logic [WORD_BITS-1:0] sh,
                                         input logic [WORD_BITS-1:0] rd);
        if (s == ST_TX) begin
            next_tx_bit = sh[WORD_BITS-1];
        end else begin
            next_tx_bit = rd[WORD_BITS-1];
        end
    endfunction

    // The pin is open drain: only the enable moves, and a released line is pulled high outside.
    assign SDA_O = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Array side strobes and status.
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            WR_DATA_O   <= SHIFT_RST;
            WR_VALID_O  <= 1'b0;
            RD_NEXT_O   <= 1'b0;
            STOP_O      <= 1'b0;
            pend_stop   <= 1'b0;
            STANDBY_O   <= 1'b1;
            READ_MODE_O <= 1'b0;
        end else begin
            WR_VALID_O  <= (state == ST_RX) && word_done;
            RD_NEXT_O   <= (state == ST_MACK) && scl.rise && mack_ok;
            STOP_O      <= cond.stop;
            READ_MODE_O <= read_mode;
            if ((state == ST_RX) && word_done) begin
                WR_DATA_O <= {shift[WORD_BITS-2:0], sda.level};
            end
            if (cond.stop) begin
                pend_stop <= 1'b1;
            end else if (cond.start) begin
                pend_stop <= 1'b0;
            end
            // Standby waits for the array to finish after a stop; a read stop goes at once.
            STANDBY_O <= (state == ST_STANDBY) && (!WRITE_BUSY_I || !pend_stop || read_mode);
        end
    end
endmodule

// File: verif/tweb_master.sv
// Purpose: Behavioural two-wire bus master driving the serial pins.
// Assumes: Pull-up on the data line; clock period 125 ns within frames.
// Notes:   The clock stands high between frames.
module tweb_master (
    output logic      scl_o,
    output logic      sda_oe_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime H = 62.5;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Data moves an eighth of a period after the clock falls, so the target never sees both move together.
    task automatic bit_x(input logic b, output logic r);
        #(H / 4) sda_oe_o = !b;
        #(3 * H / 4) scl_o = 1'b1;
        #(H / 2) r = sda_i;
        #(H / 2) scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    endtask
    task automatic start();
        if (!scl_o) begin
            #(H / 4) sda_oe_o = 1'b0;
            #(3 * H / 4) scl_o = 1'b1;
            #H;
        end
        sda_oe_o = 1'b1;
        #H scl_o = 1'b0;
    endtask
    task automatic stop();
        #(H / 4) sda_oe_o = 1'b1;
        #(3 * H / 4) scl_o = 1'b1;
        #H sda_oe_o = 1'b0;
        #H;
    endtask
    task automatic recover(output logic r);
        #H scl_o = 1'b0;
        repeat (9) bit_x(1'b1, r);
    endtask
endmodule

// File: verif/tweb_target_properties.sv
// Purpose: Port-level properties of the two-wire target.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Serial pins are raw; the target sees them a few cycles late.
module tweb_target_properties (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic WRITE_BUSY_I,
    input wire logic RD_NEXT_O,
    input wire logic WR_VALID_O,
    input wire logic STOP_O,
    input wire logic STANDBY_O,
    input wire logic READ_MODE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_low_only; SDA_O == 1'b0; endproperty
    a_low_only: assert property (p_low_only) else $error("data pin driven high");
    property p_ack_hold; $rose(SDA_OE_O) |-> SDA_OE_O [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge too short");
    property p_edge_clk_low; $rose(SDA_OE_O) || $fell(SDA_OE_O) |-> !SCL_I; endproperty
    a_edge_clk_low: assert property (p_edge_clk_low) else $error("drive changed with clock high");
    property p_hold_high; SCL_I [*4] |-> $stable(SDA_OE_O); endproperty
    a_hold_high: assert property (p_hold_high) else $error("drive moved in clock high");
    property p_stop_free; STOP_O |-> !SDA_OE_O ##1 !STOP_O; endproperty
    a_stop_free: assert property (p_stop_free) else $error("stop pulse wrong");
    property p_wr_dir; WR_VALID_O |-> !READ_MODE_O && !STANDBY_O ##1 !WR_VALID_O; endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("write byte in wrong mode");
    property p_rd_stop; STOP_O && READ_MODE_O |-> ##[0:3] STANDBY_O; endproperty
    a_rd_stop: assert property (p_rd_stop) else $error("no standby after read stop");
    property p_idle_stop; STOP_O && !WRITE_BUSY_I |-> ##[0:3] STANDBY_O; endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("no standby after stop");
    property p_busy_quiet; $rose(SDA_OE_O) |-> !WRITE_BUSY_I && !STANDBY_O; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("acknowledge while refused");
    c_ack: cover property ($rose(SDA_OE_O));
    c_next: cover property (RD_NEXT_O);
    c_busy_stop: cover property (STOP_O && WRITE_BUSY_I);
endmodule
bind tweb_target tweb_target_properties chk_u (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .WRITE_BUSY_I(WRITE_BUSY_I), .RD_NEXT_O(RD_NEXT_O),
    .WR_VALID_O(WR_VALID_O), .STOP_O(STOP_O), .STANDBY_O(STANDBY_O), .READ_MODE_O(READ_MODE_O));

// File: verif/tweb_target_tb.sv
// Purpose: Self-checking bench for the two-wire target.
// Assumes: Target select wired to 5; master model owns the serial clock.
// Notes:   The data wire is low whenever either party enables its pull-down.
module tweb_target_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tweb_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, busy = 1'b0;
    logic [7:0] rd_data = 8'h_0096, last_wr = 8'h_0000;
    wire logic scl, m_oe, d_oe, sda, wv, rn, st, sb, rm;
    wire logic [7:0] wd;
    int fails = 0, check_count = 0, wr_cnt = 0, stop_cnt = 0, nxt_cnt = 0;
    assign sda = !(m_oe | d_oe);
    always #5 mclk = ~mclk;
    tweb_master m_u (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
    tweb_target dut_u (.MCLK_I(mclk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE_O(d_oe), .DEV_SEL_I(3'h_5), .WRITE_BUSY_I(busy), .RD_DATA_I(rd_data),
        .RD_NEXT_O(rn), .WR_DATA_O(wd), .WR_VALID_O(wv), .STOP_O(st), .STANDBY_O(sb),
        .READ_MODE_O(rm));
    always @(posedge mclk) begin
        if (wv) last_wr <= wd;
        wr_cnt <= wr_cnt + int'(wv);
        stop_cnt <= stop_cnt + int'(st);
        nxt_cnt <= nxt_cnt + int'(rn);
        if (rn) rd_data <= 8'h_005A;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic addr(input logic [2:0] sel, input logic rw, output logic a);
        logic [7:0] q;
        m_u.start();
        m_u.xfer({TYPE_CODE, sel, rw}, q);
        m_u.bit_x(1'b1, a);
    endtask
    task automatic t_write();
        logic a;
        logic [7:0] q;
        addr(3'h_5, 1'b0, a);
        check(a, 0);
        m_u.xfer(8'h_00A5, q);
        m_u.bit_x(1'b1, a);
        check(a, 0);
        check(last_wr, 8'h_00A5);
        m_u.xfer(8'h_003C, q);
        m_u.bit_x(1'b1, a);
        check(a, 0);
        check(last_wr, 8'h_003C);
        check(rm, 0);
        @(posedge mclk) busy <= 1'b1;
        m_u.stop();
        repeat (8) @(posedge mclk);
        check(sb, 0);
        addr(3'h_5, 1'b0, a);
        check(a, 1);
        m_u.stop();
        @(posedge mclk) busy <= 1'b0;
        repeat (8) @(posedge mclk);
        check(sb, 1);
        check(stop_cnt, 2);
        $display("write test done");
    endtask
    task automatic t_read();
        logic a;
        logic [7:0] q;
        addr(3'h_5, 1'b1, a);
        check(a, 0);
        check(rm, 1);
        m_u.xfer(8'h_00FF, q);
        check(q, 8'h_0096);
        m_u.bit_x(1'b0, a);
        m_u.xfer(8'h_00FF, q);
        check(q, 8'h_005A);
        m_u.bit_x(1'b1, a);
        m_u.stop();
        repeat (4) @(posedge mclk);
        check(sb, 1);
        check(nxt_cnt, 1);
        $display("read test done");
    endtask
    task automatic t_mismatch();
        logic a;
        logic [7:0] q;
        addr(3'h_2, 1'b0, a);
        check(a, 1);
        m_u.xfer(8'h_0000, q);
        m_u.bit_x(1'b1, a);
        check(a, 1);
        check(wr_cnt, 2);
        check(sb, 1);
        m_u.stop();
        $display("mismatch test done");
    endtask
    task automatic t_abort();
        logic a;
        logic [7:0] q;
        m_u.recover(a);
        check(a, 1);
        m_u.xfer({TYPE_CODE, 3'h_5, 1'b0}, q);
        m_u.bit_x(1'b1, a);
        check(a, 1);
        m_u.start();
        for (int i = 0; i < 4; i++) m_u.bit_x(i[0], a);
        addr(3'h_5, 1'b0, a);
        check(a, 0);
        m_u.stop();
        $display("abort test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        t_write();
        t_read();
        t_mismatch();
        t_abort();
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
endmodule
